// ===== common/sdram_init_map.vh
// Timing counts, command codes and register offsets of the memory power-up controller
`ifndef SDRAM_INIT_MAP_VH
`define SDRAM_INIT_MAP_VH

`define CLK_PERIOD_PS        8000
// Times in their own units
`define T_TEST_LOW_US        700
`define T_CKE_SETUP_NS       10
`define T_INIT_WAIT_US       500
`define T_CLK_STABLE_NS      10
`define T_CLK_STABLE_CK      5
`define T_RESET_PULSE_US     200
`define T_START_LIMIT_MS     64
// Cycle counts derived from the 8 ns clock, least times rounded up
`define CYC_RESET_PULSE      ((`T_RESET_PULSE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_TEST_LOW         ((`T_TEST_LOW_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_CKE_SETUP        ((`T_CKE_SETUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_INIT_WAIT        ((`T_INIT_WAIT_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_CLK_STABLE_NS    ((`T_CLK_STABLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Memory clock divider: memory clock period in controller cycles
`define MEM_CLK_DIV          4

// Command codes on the command bus (cs_n, act_n, ras, cas, we)
`define CMD_DESELECT         5'h1f
`define CMD_MODE_SET         5'h08
`define CMD_CALIBRATE        5'h0e

// Register offsets (byte addresses)
`define REG_CONTROL          8'h00
`define REG_STATUS           8'h04
`define REG_MR0              8'h08
`define REG_TIMING_A         8'h24
`define REG_TIMING_B         8'h28
// Control fields
`define CTRL_START           0
`define CTRL_ODT_LEVEL       1
// Status fields
`define STAT_BUSY            0
`define STAT_DONE            1
`define STAT_CKE             2
// Default memory-clock counts for the initialization timings
`define DEF_MRD              8'h08
`define DEF_MOD              8'h18
`define DEF_XPR              16'h0100
`define DEF_DLLK             16'h0400
`define DEF_ZQINIT           16'h0400
`define AXI_OKAY             2'h0
`define AXI_SLVERR           2'h2

`endif

// ===== hdl/sdram_init_ctrl.v
// Memory power-up and initialization controller with an AXI4-Lite register port
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "sdram_init_map.vh"

module sdram_init_ctrl #(
	parameter integer RESET_PULSE_CYC = `CYC_RESET_PULSE,
	parameter integer TEST_LOW_CYC    = `CYC_TEST_LOW,
	parameter integer INIT_WAIT_CYC   = `CYC_INIT_WAIT
) (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         o_reset_n,
	output reg         o_test_mode_enable_pin,
	output reg         o_cke,
	output reg         o_clock_true,
	output reg         o_clock_complement,
	output reg         o_termination_control_pin,
	output reg  [4:0]  o_cmd,
	output reg  [2:0]  o_mr_select,
	output reg  [17:0] o_addr
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [9:0] ST_IDLE   = 10'h001;
localparam [9:0] ST_RESET  = 10'h002;
localparam [9:0] ST_CKELOW = 10'h004;
localparam [9:0] ST_WAIT   = 10'h008;
localparam [9:0] ST_CLKRUN = 10'h010;
localparam [9:0] ST_XPR    = 10'h020;
localparam [9:0] ST_MRS    = 10'h040;
localparam [9:0] ST_MRGAP  = 10'h080;
localparam [9:0] ST_ZQ     = 10'h100;
localparam [9:0] ST_DONE   = 10'h200;

// ----------------------------------------
// Registers and bus slave
// ----------------------------------------
reg        ctrl_odt_level;
reg [17:0] mr_value [0:6];
reg [7:0]  t_mrd;
reg [7:0]  t_mod;
reg [15:0] t_xpr;
reg [15:0] t_dllk;
reg [15:0] t_zqinit;
reg        start_pulse;
reg        clk_on;
reg [9:0]  state;
reg        have_aw;
reg        have_w;
reg [7:0]  aw_addr;
reg [31:0] w_data;
reg [3:0]  w_strb;
integer    k;

assign s_axi_awready = !have_aw && !s_axi_bvalid;
assign s_axi_wready  = !have_w && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire       wr_go = have_aw && have_w && !s_axi_bvalid;
wire       busy  = (state != ST_IDLE) && (state != ST_DONE);
wire [3:0] mr_idx = aw_addr[5:2] - 4'h2;
wire       wr_mr  = (aw_addr >= `REG_MR0) && (aw_addr < `REG_TIMING_A);

always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		have_aw <= 1'b0;
		have_w <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `AXI_OKAY;
		start_pulse <= 1'b0;
		ctrl_odt_level <= 1'b0;
		t_mrd <= `DEF_MRD;
		t_mod <= `DEF_MOD;
		t_xpr <= `DEF_XPR;
		t_dllk <= `DEF_DLLK;
		t_zqinit <= `DEF_ZQINIT;
		for (k = 0; k < 7; k = k + 1) begin
			mr_value[k] <= 18'h00000;
		end
	end else begin
		start_pulse <= 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			have_aw <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			have_w <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		if (wr_go) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `AXI_OKAY;
			if (aw_addr == `REG_CONTROL) begin
				if (w_strb[0]) begin
					start_pulse <= w_data[`CTRL_START] && !busy;
					// Termination level is frozen once the sequence is running
					if (!busy) begin
						ctrl_odt_level <= w_data[`CTRL_ODT_LEVEL];
					end
				end
			end else if (wr_mr) begin
				mr_value[mr_idx[2:0]] <= w_data[17:0];
			end else if (aw_addr == `REG_TIMING_A) begin
				t_mrd <= w_data[7:0];
				t_mod <= w_data[15:8];
				t_xpr <= w_data[31:16];
			end else if (aw_addr == `REG_TIMING_B) begin
				t_dllk <= w_data[15:0];
				t_zqinit <= w_data[31:16];
			end else if (aw_addr != `REG_STATUS) begin
				s_axi_bresp <= `AXI_SLVERR;
			end
		end
	end
end

always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `AXI_OKAY;
	end else begin
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `AXI_OKAY;
			if (s_axi_araddr == `REG_CONTROL) begin
				s_axi_rdata <= {30'h00000000, ctrl_odt_level, 1'b0};
			end else if (s_axi_araddr == `REG_STATUS) begin
				s_axi_rdata <= {29'h00000000, o_cke, state == ST_DONE, busy};
			end else if (s_axi_araddr == `REG_TIMING_A) begin
				s_axi_rdata <= {t_xpr, t_mod, t_mrd};
			end else if (s_axi_araddr == `REG_TIMING_B) begin
				s_axi_rdata <= {t_zqinit, t_dllk};
			end else if (s_axi_araddr >= `REG_MR0 && s_axi_araddr < `REG_TIMING_A) begin
				s_axi_rdata <= {14'h0000, mr_value[s_axi_araddr[4:2] - 3'h2]};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `AXI_SLVERR;
			end
		end
	end
end

// ----------------------------------------
// Memory clock divider
// ----------------------------------------
// Link clock is made here so every memory-clock count but the ST_CLKRUN wait (counted in controller cycles) is a tick of this divider
reg [7:0] div_cnt;
wire      ck_tick = (div_cnt == `MEM_CLK_DIV - 1);

always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		div_cnt <= 8'h00;
		o_clock_true <= 1'b0;
		o_clock_complement <= 1'b1;
	end else begin
		div_cnt <= ck_tick ? 8'h00 : div_cnt + 8'h01;
		if (clk_on && div_cnt == `MEM_CLK_DIV / 2 - 1) begin
			o_clock_true <= 1'b1;
			o_clock_complement <= 1'b0;
		end else if (ck_tick || !clk_on) begin
			o_clock_true <= 1'b0;
			o_clock_complement <= 1'b1;
		end
	end
end

// ----------------------------------------
// Sequencer
// ----------------------------------------
reg [31:0] cnt;
reg [31:0] test_cnt;
reg [2:0]  mr_step;

// Load order: 3,6,5,4,2,1,0
function [2:0] mr_of_step;
	input [2:0] s;
	begin
		case (s)
			3'd0: mr_of_step = 3'd3;
			3'd1: mr_of_step = 3'd6;
			3'd2: mr_of_step = 3'd5;
			3'd3: mr_of_step = 3'd4;
			3'd4: mr_of_step = 3'd2;
			3'd5: mr_of_step = 3'd1;
			default: mr_of_step = 3'd0;
		endcase
	end
endfunction

wire [31:0] xpr_need = (t_xpr < 16'd5) ? 32'd5 : {16'h0000, t_xpr};
wire [31:0] zq_need  = (t_dllk > t_zqinit) ? {16'h0000, t_dllk} : {16'h0000, t_zqinit};
wire [31:0] clk_need = (`CYC_CLK_STABLE_NS > `T_CLK_STABLE_CK * `MEM_CLK_DIV) ?
	`CYC_CLK_STABLE_NS : `T_CLK_STABLE_CK * `MEM_CLK_DIV;

always @(posedge i_clk or posedge i_rst) begin
	if (i_rst) begin
		state <= ST_IDLE;
		cnt <= 32'h00000000;
		test_cnt <= 32'h00000000;
		mr_step <= 3'd0;
		clk_on <= 1'b0;
		o_reset_n <= 1'b0;
		o_test_mode_enable_pin <= 1'b0;
		o_cke <= 1'b0;
		o_termination_control_pin <= 1'b0;
		o_cmd <= `CMD_DESELECT;
		o_mr_select <= 3'd0;
		o_addr <= 18'h00000;
	end else begin
		// Test enable held low throughout; counter only records the elapsed low time
		if (test_cnt < TEST_LOW_CYC) begin
			test_cnt <= test_cnt + 32'h00000001;
		end
		case (state)
			ST_IDLE: begin
				if (start_pulse) begin
					state <= ST_RESET;
					cnt <= 32'h00000000;
					o_reset_n <= 1'b0;
					o_cke <= 1'b0;
					clk_on <= 1'b0;
				end
			end
			ST_RESET: begin
				cnt <= cnt + 32'h00000001;
				// Reset low for pulse time and test-enable low time both met
				if (cnt >= RESET_PULSE_CYC && test_cnt >= TEST_LOW_CYC) begin
					state <= ST_CKELOW;
					cnt <= 32'h00000000;
				end
			end
			ST_CKELOW: begin
				cnt <= cnt + 32'h00000001;
				if (cnt >= `CYC_CKE_SETUP) begin
					o_reset_n <= 1'b1;
					state <= ST_WAIT;
					cnt <= 32'h00000000;
				end
			end
			ST_WAIT: begin
				cnt <= cnt + 32'h00000001;
				if (cnt >= INIT_WAIT_CYC) begin
					clk_on <= 1'b1;
					state <= ST_CLKRUN;
					cnt <= 32'h00000000;
				end
			end
			ST_CLKRUN: begin
				cnt <= cnt + 32'h00000001;
				o_cmd <= `CMD_DESELECT;
				if (cnt >= clk_need && ck_tick) begin
					o_cke <= 1'b1;
					o_termination_control_pin <= ctrl_odt_level;
					state <= ST_XPR;
					cnt <= 32'h00000000;
				end
			end
			ST_XPR: begin
				if (ck_tick) begin
					cnt <= cnt + 32'h00000001;
					if (cnt + 32'h00000001 >= xpr_need) begin
						state <= ST_MRS;
						mr_step <= 3'd0;
					end
				end
			end
			ST_MRS: begin
				if (ck_tick) begin
					o_cmd <= `CMD_MODE_SET;
					o_mr_select <= mr_of_step(mr_step);
					o_addr <= mr_value[mr_of_step(mr_step)];
					state <= ST_MRGAP;
					cnt <= 32'h00000000;
				end
			end
			ST_MRGAP: begin
				if (ck_tick) begin
					o_cmd <= `CMD_DESELECT;
					cnt <= cnt + 32'h00000001;
					if (mr_step == 3'd6) begin
						if (cnt + 32'h00000001 >= {24'h000000, t_mod}) begin
							o_cmd <= `CMD_CALIBRATE;
							o_addr <= 18'h00400;
							state <= ST_ZQ;
							cnt <= 32'h00000000;
						end
					end else if (cnt + 32'h00000001 >= {24'h000000, t_mrd}) begin
						mr_step <= mr_step + 3'd1;
						state <= ST_MRS;
					end
				end
			end
			ST_ZQ: begin
				if (ck_tick) begin
					o_cmd <= `CMD_DESELECT;
					o_addr <= 18'h00000;
					cnt <= cnt + 32'h00000001;
					if (cnt + 32'h00000001 >= zq_need) begin
						state <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				if (start_pulse) begin
					state <= ST_RESET;
					cnt <= 32'h00000000;
					o_reset_n <= 1'b0;
					o_cke <= 1'b0;
					clk_on <= 1'b0;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
		endcase
	end
end

endmodule

// ===== tb/sdram_init_checker.sv
// Port-level assertions for the memory power-up controller
`timescale 1ns/10ps
`include "sdram_init_map.vh"
module sdram_init_checker #(
	parameter integer RESET_PULSE_CYC = 20,
	parameter integer TEST_LOW_CYC    = 30,
	parameter integer INIT_WAIT_CYC   = 40
) (
	input wire       i_clk,
	input wire       i_rst,
	input wire       o_reset_n,
	input wire       o_test_mode_enable_pin,
	input wire       o_cke,
	input wire       o_termination_control_pin,
	input wire [4:0] o_cmd,
	input wire [2:0] o_mr_select
);
	localparam [20:0] MR_SEQ = 21'o3654210;
	reg  [4:0]  prev_cmd;
	reg  [2:0]  ms_idx;
	reg  [31:0] low_cnt;
	reg  [31:0] hi_cnt;
	reg  [31:0] gap;
	wire        cmd_start = (o_cmd != `CMD_DESELECT) && (o_cmd != prev_cmd);
	wire        ms = cmd_start && (o_cmd == `CMD_MODE_SET);

	// ----
	// Helper counters
	// ----
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_cmd <= `CMD_DESELECT;
			ms_idx   <= 3'h0;
			low_cnt  <= 32'h0;
			hi_cnt   <= 32'h0;
			gap      <= 32'h0;
		end else begin
			prev_cmd <= o_cmd;
			low_cnt  <= o_reset_n ? 32'h0 : low_cnt + 32'h1;
			hi_cnt   <= (o_reset_n && !o_cke) ? hi_cnt + 32'h1 : 32'h0;
			gap      <= (!o_cke || cmd_start) ? 32'h0 : gap + 32'h1;
			ms_idx   <= !o_cke ? 3'h0 : ms_idx + {2'h0, ms};
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	test_low_a: assert property (!o_test_mode_enable_pin)
		else $error("test enable driven high");
	reset_pulse_a: assert property ($rose(o_reset_n) |-> low_cnt >= RESET_PULSE_CYC)
		else $error("reset pulse too short");
	cke_setup_a: assert property ($rose(o_reset_n) |-> !o_cke && !$past(o_cke) && !$past(o_cke, 2))
		else $error("cke not low before reset release");
	init_wait_a: assert property ($rose(o_cke) |-> hi_cnt >= INIT_WAIT_CYC)
		else $error("cke raised too early");
	cke_deselect_a: assert property ($rose(o_cke) |-> o_cmd == `CMD_DESELECT)
		else $error("no deselect with cke rise");
	cke_hold_a: assert property (o_cke |=> o_cke || !o_reset_n)
		else $error("cke dropped during init");
	odt_static_a: assert property (o_cke && $past(o_cke) |-> $stable(o_termination_control_pin))
		else $error("termination pin moved");
	first_mrs_a: assert property (ms && ms_idx == 3'h0 |-> gap >= 5 * `MEM_CLK_DIV)
		else $error("first mode set too early");
	mrs_order_a: assert property (ms |-> o_mr_select == MR_SEQ[20 - 3 * ms_idx -: 3]
		&& (ms_idx == 3'h0 || gap >= `DEF_MRD * `MEM_CLK_DIV - 1))
		else $error("mode set order or spacing wrong");
	cmd_deselect_a: assert property (cmd_start |=> $stable(o_cmd) [*3] ##1 o_cmd == `CMD_DESELECT)
		else $error("no deselect after command");
	cal_after_mr0_a: assert property (cmd_start && o_cmd == `CMD_CALIBRATE
		|-> ms_idx == 3'h7 && gap >= `DEF_MOD * `MEM_CLK_DIV - 1)
		else $error("calibration out of place");

	cover property ($rose(o_reset_n));
	cover property ($rose(o_cke));
	cover property (cmd_start && o_cmd == `CMD_CALIBRATE);
endmodule

bind sdram_init_ctrl sdram_init_checker #(
	.RESET_PULSE_CYC(RESET_PULSE_CYC),
	.TEST_LOW_CYC(TEST_LOW_CYC),
	.INIT_WAIT_CYC(INIT_WAIT_CYC)
) u_checker (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.o_reset_n(o_reset_n),
	.o_test_mode_enable_pin(o_test_mode_enable_pin),
	.o_cke(o_cke),
	.o_termination_control_pin(o_termination_control_pin),
	.o_cmd(o_cmd),
	.o_mr_select(o_mr_select)
);

// ===== tb/sdram_device_model.sv
// Behavioural memory device seen by the power-up controller
`timescale 1ns/10ps
`include "sdram_init_map.vh"
module sdram_device_model #(
	parameter integer WRITE_LAT = 9,
	parameter integer CAL_CK    = 1024
) (
	input  wire        i_ck_t,
	input  wire        i_reset_n,
	input  wire        i_cke,
	input  wire        i_odt,
	input  wire [4:0]  i_cmd,
	input  wire [2:0]  i_mr_sel,
	input  wire [17:0] i_addr,
	output reg         o_rtt_on,
	output reg         o_ready
);
	reg     [17:0] mode_reg [0:6];
	reg     [15:0] odt_pipe;
	reg            cke_seen;
	integer        cal;
	integer        k;

	// ----
	// Device state, clock-free while in reset
	// ----
	always @(posedge i_ck_t or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cke_seen <= 1'b0;
			o_rtt_on <= 1'b0;
			o_ready  <= 1'b0;
			cal      <= 0;
			odt_pipe <= 16'h0;
			for (k = 0; k < 7; k = k + 1)
				mode_reg[k] <= 18'hx;
		end else begin
			if (i_cke)
				cke_seen <= 1'b1;
			odt_pipe <= {odt_pipe[14:0], i_odt};
			o_rtt_on <= cke_seen && odt_pipe[WRITE_LAT - 3];
			if (cke_seen && i_cmd == `CMD_MODE_SET)
				mode_reg[i_mr_sel] <= i_addr;
			if (cke_seen && i_cmd == `CMD_CALIBRATE)
				cal <= CAL_CK;
			else if (cal > 1)
				cal <= cal - 1;
			if (cal == 1)
				o_ready <= 1'b1;
		end
	end
endmodule

// ===== tb/sdram_init_ctrl_tb_top.sv
// Self-checking bench for the memory power-up controller
`timescale 1ns/10ps
`include "sdram_init_map.vh"
module sdram_init_ctrl_tb_top;
	reg         i_clk = 0;
	reg         i_rst = 1;
	reg  [7:0]  awaddr = 0;
	reg         awvalid = 0;
	reg  [31:0] wdata = 0;
	reg         wvalid = 0;
	reg         bready = 0;
	reg  [7:0]  araddr = 0;
	reg         arvalid = 0;
	reg         rready = 0;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire        reset_n, cke, ck_t, termination_control_pin, rtt, dev_ready;
	wire [4:0]  cmd;
	wire [2:0]  mr_sel;
	wire [17:0] addr;
	reg  [1:0]  bq [$];
	reg  [65:0] rq [$];
	reg  [1:0]  be;
	reg  [65:0] re;
	reg  [31:0] mr [0:6];
	reg  [31:0] st;
	reg         odt_lvl;
	integer     seed = 79803;
	integer     i, n;
	integer     failures = 0;
	integer     samples_checked = 0;

	always #4 i_clk = ~i_clk;

	sdram_init_ctrl #(.RESET_PULSE_CYC(20), .TEST_LOW_CYC(30), .INIT_WAIT_CYC(40)) u_dut (
		.i_clk(i_clk), .i_rst(i_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.o_reset_n(reset_n), .o_test_mode_enable_pin(), .o_cke(cke), .o_clock_true(ck_t),
		.o_clock_complement(), .o_termination_control_pin(termination_control_pin), .o_cmd(cmd),
		.o_mr_select(mr_sel), .o_addr(addr));

	sdram_device_model u_mem (.i_ck_t(ck_t), .i_reset_n(reset_n), .i_cke(cke), .i_odt(termination_control_pin),
		.i_cmd(cmd), .i_mr_sel(mr_sel), .i_addr(addr), .o_rtt_on(rtt), .o_ready(dev_ready));

	// ----
	// Bus tasks and checking
	// ----
	task cmp(input [31:0] got, input [31:0] exp, input [31:0] mask);
		begin
			samples_checked = samples_checked + 1;
			if (((got ^ exp) & mask) !== 32'h0) begin
				failures = failures + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task axw(input [7:0] a, input [31:0] d, input [1:0] r);
		reg ad, wd;
		begin
			@(posedge i_clk);
			bq.push_back(r);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
			ad = 0;
			wd = 0;
			while (!(ad && wd)) begin
				@(posedge i_clk);
				if (awvalid && awready) begin
					ad = 1;
					awvalid <= 0;
				end
				if (wvalid && wready) begin
					wd = 1;
					wvalid <= 0;
				end
			end
			while (!bvalid) @(posedge i_clk);
			bready <= 0;
		end
	endtask

	task axr(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] r, output [31:0] d);
		begin
			@(posedge i_clk);
			rq.push_back({r, m, e});
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
			do @(posedge i_clk); while (!arready);
			arvalid <= 0;
			while (!rvalid) @(posedge i_clk);
			d = rdata;
			rready <= 0;
		end
	endtask

	always @(posedge i_clk) begin
		if (bvalid && bready) begin
			be = bq.pop_front();
			cmp({30'h0, bresp}, {30'h0, be}, 32'h3);
		end
		if (rvalid && rready) begin
			re = rq.pop_front();
			cmp(rdata, re[31:0], re[63:32]);
			cmp({30'h0, rresp}, {30'h0, re[65:64]}, 32'h3);
		end
	end

	task results;
		begin
			$display("checked %0d mismatches %0d", samples_checked, failures);
			if (failures == 0 && samples_checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst <= 0;
		axr(`REG_STATUS, 32'h0, 32'h7, `AXI_OKAY, st);
		axr(`REG_TIMING_A, 32'h01001808, ~32'h0, `AXI_OKAY, st);
		axr(`REG_TIMING_B, 32'h04000400, ~32'h0, `AXI_OKAY, st);
		axr(8'h40, 32'h0, 32'h0, `AXI_SLVERR, st);
		axw(8'h40, 32'h0, `AXI_SLVERR);
		for (i = 0; i < 7; i = i + 1) begin
			mr[i] = $random(seed);
			axw(`REG_MR0 + {i[5:0], 2'h0}, mr[i], `AXI_OKAY);
		end
		axr(`REG_MR0 + 8'h0c, mr[3], 32'h3ffff, `AXI_OKAY, st);
		odt_lvl = $random(seed);
		axw(`REG_CONTROL, {30'h0, odt_lvl, 1'b1}, `AXI_OKAY);
		axw(`REG_CONTROL, {30'h0, odt_lvl, 1'b1}, `AXI_OKAY);
		axr(`REG_STATUS, 32'h1, 32'h7, `AXI_OKAY, st);
		cmp({31'h0, rtt}, 32'h0, 32'h1);
		n = 0;
		st = 0;
		while (!st[1] && n < 3000) begin
			axr(`REG_STATUS, 32'h0, 32'h0, `AXI_OKAY, st);
			n = n + 1;
		end
		axr(`REG_STATUS, 32'h6, 32'h7, `AXI_OKAY, st);
		cmp({31'h0, termination_control_pin}, {31'h0, odt_lvl}, 32'h1);
		cmp({31'h0, rtt}, {31'h0, odt_lvl}, 32'h1);
		cmp({31'h0, dev_ready}, 32'h1, 32'h1);
		for (i = 0; i < 7; i = i + 1)
			cmp({14'h0, u_mem.mode_reg[i]}, {14'h0, mr[i][17:0]}, ~32'h0);
		results;
	end

	initial begin
		#400000;
		failures = failures + 1;
		$display("[ERR] %0t watchdog expired", $time);
		results;
	end
endmodule
